// file: hdl/pcp_consts.vh
`ifndef PCP_CONSTS_VH
`define PCP_CONSTS_VH
// loop power field codes
`define PCP_PWR_NORMAL 2'h0
`define PCP_PWR_ASYNC_DOWN 2'h1
`define PCP_PWR_RESET 2'h1
// oscillator divider select
`define PCP_DIVSEL_RESET 3'h0
`define PCP_DIVSEL_W 3
// charge pump modes
`define PCP_CP_HIZ 2'h0
`define PCP_CP_NORMAL 2'h3
`define PCP_CP_UP 2'h1
`define PCP_CP_DOWN 2'h2
`define PCP_CP_MODE_RESET 2'h0
// pump current code, eight steps
`define PCP_ICP_W 3
`define PCP_ICP_RESET 3'h7
// anti-backlash width
`define PCP_ABL_RESET 2'h0
// calibration sequencer states
`define PCP_CAL_IDLE 2'h0
`define PCP_CAL_ARMED 2'h1
`define PCP_CAL_RUN 2'h2
`define PCP_CAL_TIME_US 20
`define PCP_CAL_CYC ((`PCP_CAL_TIME_US * 25) / 1)
`endif

// file: hdl/pcp_div_ctr.v
`timescale 1ns/1ns
`include "pcp_consts.vh"
// programmable divider model, code 0 -> /2, codes 1..6 -> /1../6
module pcp_div_ctr #(
  parameter W = 3
) (
  input wire mclk, // clock
  input wire rst_n, // synchronised reset, low active
  input wire [W-1:0] div_sel, // divide select code
  input wire clk_in, // input clock enable level
  output reg clk_out // divided tick
);
  reg [W-1:0] cnt_r;
  reg [W-1:0] ratio;
  always @* begin
    ratio = div_sel;
    if (div_sel == `PCP_DIVSEL_RESET)
      ratio = 3'h2;
    else if (div_sel > 3'h6)
      ratio = 3'h6;
  end
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 3'h0;
      clk_out <= 1'b0;
    end else if (clk_in) begin
      if (cnt_r + 3'h1 >= ratio) begin
        cnt_r <= 3'h0;
        clk_out <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 3'h1;
        clk_out <= 1'b0;
      end
    end else begin
      clk_out <= 1'b0;
    end
  end
endmodule // pcp_div_ctr

// file: hdl/pcp_top.v
`timescale 1ns/1ns
`include "pcp_consts.vh"
// Functional notes
// - after reset loop held in async power-down, power field reads 01
// - divider select resets to 000, which means divide by two; ratios 1..6
// - default routes external input through divider to distribution
// - external input with loop on keeps internal oscillator off
// - polarity bit 0 positive, 1 negative
// - polarity matters only with external oscillator; internal fixed positive
// - detector compares reference and feedback, commands pump up or down
// - two-bit field selects anti-backlash pulse width
// - pump mode: high impedance, normal, constant up, constant down
// - pump current in eight equal steps
module pcp_top #(
  parameter CAL_CYC = `PCP_CAL_CYC
) (
  input wire mclk, // 25 MHz clock
  input wire rst_n, // async reset, low active
  input wire update_stb, // register update strobe
  input wire [1:0] pwr_mode, // loop power field
  input wire [2:0] div_sel, // oscillator divider select
  input wire src_osc, // 1 selects internal oscillator
  input wire div_bypass, // 1 bypasses divider
  input wire pol_neg, // detector polarity
  input wire [1:0] abl_width, // anti-backlash width
  input wire [1:0] cp_mode, // pump mode
  input wire [2:0] icp_code, // pump current code
  input wire cal_req, // calibration bit
  input wire ref_edge, // reference divider output tick
  input wire fb_edge, // feedback divider output tick
  input wire ext_clk_tick, // external input tick
  output reg [1:0] pwr_mode_q, // active loop power field
  output reg loop_pd, // loop powered down
  output reg osc_en, // internal oscillator enable
  output reg osc_to_presc, // internal osc feeds prescaler
  output reg [2:0] div_sel_q, // active divider select
  output reg dist_bypass, // distribution takes undivided source
  output reg dist_src_osc, // distribution source is oscillator
  output reg dist_tick, // tick into distribution
  output reg pol_eff, // effective polarity
  output reg [1:0] abl_q, // active anti-backlash width
  output reg [2:0] icp_q, // active pump current code
  output reg pump_up, // pump up command
  output reg pump_dn, // pump down command
  output reg pump_hiz, // pump output high impedance
  output reg cal_busy, // calibration running
  output reg cal_done // calibration finished
);
  ////////////////////////////////////////////////////////////////////
  reg rs1_r, rs2_r;
  wire srst_n = rs2_r;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rs1_r <= 1'b0;
      rs2_r <= 1'b0;
    end else begin
      rs1_r <= 1'b1;
      rs2_r <= rs1_r;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // shadow registers loaded on update strobe
  reg [1:0] pwr_r, cpm_r, abl_r;
  reg [2:0] dsel_r, icp_r;
  reg src_r, byp_r, pol_r;
  always @(posedge mclk or negedge srst_n) begin
    if (!srst_n) begin
      pwr_r <= `PCP_PWR_RESET;
      dsel_r <= `PCP_DIVSEL_RESET;
      src_r <= 1'b0;
      byp_r <= 1'b0;
      pol_r <= 1'b0;
      abl_r <= `PCP_ABL_RESET;
      cpm_r <= `PCP_CP_MODE_RESET;
      icp_r <= `PCP_ICP_RESET;
    end else if (update_stb) begin
      pwr_r <= pwr_mode;
      dsel_r <= div_sel;
      src_r <= src_osc;
      byp_r <= div_bypass;
      pol_r <= pol_neg;
      abl_r <= abl_width;
      cpm_r <= cp_mode;
      icp_r <= icp_code;
    end
  end
  wire loop_on = (pwr_r == `PCP_PWR_NORMAL);
  ////////////////////////////////////////////////////////////////////
  // divider in the distribution path
  wire div_tick;
  pcp_div_ctr #(.W(`PCP_DIVSEL_W)) u_div (
    .mclk(mclk),
    .rst_n(srst_n),
    .div_sel(dsel_r),
    .clk_in(ext_clk_tick),
    .clk_out(div_tick)
  );
  ////////////////////////////////////////////////////////////////////
  // detector: latch each edge, clear both after anti-backlash overlap
  reg up_r, dn_r;
  reg [1:0] abl_cnt_r;
  always @(posedge mclk or negedge srst_n) begin
    if (!srst_n) begin
      up_r <= 1'b0;
      dn_r <= 1'b0;
      abl_cnt_r <= 2'h0;
    end else if (up_r && dn_r) begin
      if (abl_cnt_r >= abl_r) begin
        up_r <= ref_edge;
        dn_r <= fb_edge;
        abl_cnt_r <= 2'h0;
      end else begin
        abl_cnt_r <= abl_cnt_r + 2'h1;
      end
    end else begin
      if (ref_edge)
        up_r <= 1'b1;
      if (fb_edge)
        dn_r <= 1'b1;
    end
  end
  // external path honours polarity, internal fixed positive
  wire pol_w = src_r ? 1'b0 : pol_r;
  ////////////////////////////////////////////////////////////////////
  // calibration: arm on cleared bit, run on set bit with strobe
  reg [1:0] cal_st_r;
  reg [31:0] cal_cnt_r;
  reg cal_first_r;
  always @(posedge mclk or negedge srst_n) begin
    if (!srst_n) begin
      cal_st_r <= `PCP_CAL_ARMED;
      cal_cnt_r <= 32'h0;
      cal_first_r <= 1'b1;
    end else begin
      case (cal_st_r)
        `PCP_CAL_IDLE: begin
          if (update_stb && !cal_req)
            cal_st_r <= `PCP_CAL_ARMED;
        end
        `PCP_CAL_ARMED: begin
          if (update_stb && cal_req) begin
            cal_st_r <= `PCP_CAL_RUN;
            cal_cnt_r <= 32'h0;
            cal_first_r <= 1'b0;
          end
        end
        `PCP_CAL_RUN: begin
          if (cal_cnt_r >= CAL_CYC - 1)
            cal_st_r <= `PCP_CAL_IDLE;
          else
            cal_cnt_r <= cal_cnt_r + 32'h1;
        end
        default: cal_st_r <= `PCP_CAL_IDLE;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////
  always @(posedge mclk or negedge srst_n) begin
    if (!srst_n) begin
      pwr_mode_q <= `PCP_PWR_RESET;
      loop_pd <= 1'b1;
      osc_en <= 1'b0;
      osc_to_presc <= 1'b0;
      div_sel_q <= `PCP_DIVSEL_RESET;
      dist_bypass <= 1'b0;
      dist_src_osc <= 1'b0;
      dist_tick <= 1'b0;
      pol_eff <= 1'b0;
      abl_q <= `PCP_ABL_RESET;
      icp_q <= `PCP_ICP_RESET;
      pump_up <= 1'b0;
      pump_dn <= 1'b0;
      pump_hiz <= 1'b1;
      cal_busy <= 1'b0;
      cal_done <= 1'b0;
    end else begin
      pwr_mode_q <= pwr_r;
      loop_pd <= !loop_on;
      osc_en <= src_r;
      osc_to_presc <= src_r;
      div_sel_q <= dsel_r;
      dist_bypass <= byp_r;
      dist_src_osc <= src_r;
      dist_tick <= byp_r ? ext_clk_tick : div_tick;
      pol_eff <= pol_w;
      abl_q <= abl_r;
      icp_q <= icp_r;
      cal_busy <= (cal_st_r == `PCP_CAL_RUN);
      cal_done <= (cal_st_r == `PCP_CAL_IDLE) && !cal_first_r;
      pump_hiz <= !loop_on || (cpm_r == `PCP_CP_HIZ);
      case (cpm_r)
        `PCP_CP_NORMAL: begin
          // both pumps on during the anti-backlash overlap
          pump_up <= loop_on && (pol_w ? dn_r : up_r);
          pump_dn <= loop_on && (pol_w ? up_r : dn_r);
        end
        `PCP_CP_UP: begin
          pump_up <= loop_on;
          pump_dn <= 1'b0;
        end
        `PCP_CP_DOWN: begin
          pump_up <= 1'b0;
          pump_dn <= loop_on;
        end
        default: begin
          pump_up <= 1'b0;
          pump_dn <= 1'b0;
        end
      endcase
    end
  end
endmodule // pcp_top

// file: sim/pcp_top_properties.sv
`timescale 1ns/1ns
`include "pcp_consts.vh"
module pcp_top_chk #(
  parameter CAL_CYC = 8
) (
  input wire mclk, rst_n, update_stb, src_osc, div_bypass, pol_neg, // controls
  input wire [1:0] pwr_mode, abl_width, cp_mode, pwr_mode_q, abl_q, // fields
  input wire [2:0] div_sel, icp_code, div_sel_q, icp_q, // codes
  input wire loop_pd, osc_en, osc_to_presc, dist_bypass, dist_src_osc, pol_eff, // state
  input wire pump_up, pump_dn, pump_hiz, cal_busy, cal_done // status
);
  // length of the current busy run
  reg [15:0] bsy_n = 16'h0;
  always @(posedge mclk) bsy_n <= cal_busy ? bsy_n + 16'h1 : 16'h0;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  //////////
  property p_pwr_rst; $rose(rst_n) |-> pwr_mode_q == `PCP_PWR_RESET && loop_pd; endproperty
  a_pwr_rst: assert property (p_pwr_rst) else $error("loop not down after reset");
  property p_div_rst; $rose(rst_n) |-> div_sel_q == 3'h0 && !dist_bypass && !dist_src_osc;
  endproperty
  a_div_rst: assert property (p_div_rst) else $error("bad default routing");
  property p_pwr_ld; update_stb |-> ##2 pwr_mode_q == $past(pwr_mode, 2)
    && loop_pd == ($past(pwr_mode, 2) != `PCP_PWR_NORMAL); endproperty
  a_pwr_ld: assert property (p_pwr_ld) else $error("power field not applied");
  property p_div_ld; update_stb |-> ##2 div_sel_q == $past(div_sel, 2)
    && dist_bypass == $past(div_bypass, 2) && dist_src_osc == $past(src_osc, 2); endproperty
  a_div_ld: assert property (p_div_ld) else $error("routing not applied");
  property p_osc_off; !dist_src_osc |-> !osc_en && !osc_to_presc; endproperty
  a_osc_off: assert property (p_osc_off) else $error("oscillator on with ext src");
  property p_pol; update_stb |-> ##2 pol_eff == ($past(pol_neg, 2) && !$past(src_osc, 2));
  endproperty
  a_pol: assert property (p_pol) else $error("wrong effective polarity");
  property p_cp_hiz; update_stb && cp_mode == `PCP_CP_HIZ |-> ##2 pump_hiz && !pump_up
    && !pump_dn; endproperty
  a_cp_hiz: assert property (p_cp_hiz) else $error("pump not high impedance");
  property p_cp_up; update_stb && cp_mode == `PCP_CP_UP && pwr_mode == `PCP_PWR_NORMAL
    && !pol_neg |-> ##2 pump_up && !pump_dn && !pump_hiz; endproperty
  a_cp_up: assert property (p_cp_up) else $error("constant up not held");
  property p_icp_ld; update_stb |-> ##2 icp_q == $past(icp_code, 2)
    && abl_q == $past(abl_width, 2); endproperty
  a_icp_ld: assert property (p_icp_ld) else $error("current or width not applied");
  property p_cal; $fell(cal_busy) |-> bsy_n == CAL_CYC && cal_done; endproperty
  a_cal: assert property (p_cal) else $error("calibration length wrong");
endmodule // pcp_top_chk
bind pcp_top pcp_top_chk #(.CAL_CYC(CAL_CYC)) chk_u (.*);

// file: sim/pcp_ext_src.sv
`timescale 1ns/1ns
module pcp_ext_src (
  input wire mclk, // clock
  input wire [3:0] lag, // feedback delay behind reference
  output reg ref_edge = 1'b0, // reference tick
  output reg fb_edge = 1'b0, // feedback tick
  output reg ext_clk_tick = 1'b0 // oscillator tick
);
  reg [3:0] ph = 4'h0;
  always @(negedge mclk) begin
    ph <= ph + 4'h1;
    ref_edge <= ph == 4'h0;
    fb_edge <= ph == lag;
    ext_clk_tick <= ~ph[0];
  end
endmodule // pcp_ext_src

// file: sim/tb_pcp_top.sv
`timescale 1ns/1ns
`include "pcp_consts.vh"
module tb_pcp_top;
  reg mclk = 1'b0, rst_n = 1'b0, update_stb = 1'b0, src_osc = 1'b0, div_bypass = 1'b0;
  reg pol_neg = 1'b0, cal_req = 1'b0;
  reg [1:0] pwr_mode = 2'h1, abl_width = 2'h0, cp_mode = 2'h0;
  reg [2:0] div_sel = 3'h0, icp_code = 3'h0;
  reg [1:0] s = 2'h0;
  reg [3:0] lag = 4'h3;
  reg [15:0] lf = 16'ha25e;
  reg [13:0] q[$];
  wire ref_edge, fb_edge, ext_clk_tick, loop_pd, osc_en, osc_to_presc, dist_bypass;
  wire dist_src_osc, dist_tick, pol_eff, pump_up, pump_dn, pump_hiz, cal_busy, cal_done;
  wire [1:0] pwr_mode_q, abl_q;
  wire [2:0] div_sel_q, icp_q;
  wire [13:0] obs = {pwr_mode_q, loop_pd, div_sel_q, dist_bypass, dist_src_osc, pol_eff,
    abl_q, icp_q};
  integer n_errors = 0, checked = 0, cyc = 0, nu = 0, nd = 0, nb = 0, nt = 0, i;
  always #20 mclk = ~mclk;
  pcp_top #(.CAL_CYC(8)) dut_u (.mclk(mclk), .rst_n(rst_n), .update_stb(update_stb),
    .pwr_mode(pwr_mode), .div_sel(div_sel), .src_osc(src_osc), .div_bypass(div_bypass),
    .pol_neg(pol_neg), .abl_width(abl_width), .cp_mode(cp_mode), .icp_code(icp_code),
    .cal_req(cal_req), .ref_edge(ref_edge), .fb_edge(fb_edge), .ext_clk_tick(ext_clk_tick),
    .pwr_mode_q(pwr_mode_q), .loop_pd(loop_pd), .osc_en(osc_en), .osc_to_presc(osc_to_presc),
    .div_sel_q(div_sel_q), .dist_bypass(dist_bypass), .dist_src_osc(dist_src_osc),
    .dist_tick(dist_tick), .pol_eff(pol_eff), .abl_q(abl_q), .icp_q(icp_q),
    .pump_up(pump_up), .pump_dn(pump_dn), .pump_hiz(pump_hiz), .cal_busy(cal_busy),
    .cal_done(cal_done));
  pcp_ext_src ext_u (.mclk(mclk), .lag(lag), .ref_edge(ref_edge), .fb_edge(fb_edge),
    .ext_clk_tick(ext_clk_tick));
  //////////
  task chk(input [15:0] got, input [15:0] exp); begin
    checked = checked + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  end endtask
  task test_done; begin
    if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  end endtask
  function [15:0] nxt(input [15:0] v);
    nxt = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task cfg(input [1:0] pm, input [2:0] ds, input so, bp, pn, input [1:0] ab, cm,
    input [2:0] ic); begin
    @(negedge mclk);
    {pwr_mode, div_sel, src_osc, div_bypass, pol_neg} = {pm, ds, so, bp, pn};
    {abl_width, cp_mode, icp_code} = {ab, cm, ic};
    update_stb = 1'b1;
    q.push_back({pm, pm == `PCP_PWR_ASYNC_DOWN, ds, bp, so, pn & ~so, ab, ic});
  end endtask
  task idle(input integer n); begin
    @(negedge mclk);
    update_stb = 1'b0;
    repeat (n) @(negedge mclk);
  end endtask
  task rst; begin
    @(negedge mclk);
    rst_n = 1'b0;
    repeat (4) @(negedge mclk);
    chk({obs, pump_hiz}, {2'h1, 1'b1, 3'h0, 3'h0, 2'h0, 3'h7, 1'b1});
    rst_n = 1'b1;
    repeat (3) @(negedge mclk);
  end endtask
  // outputs settle one edge after the capture edge
  always @(posedge mclk) s <= {s[0], update_stb};
  always @(negedge mclk) begin
    cyc = cyc + 1;
    nu = nu + pump_up;
    nd = nd + pump_dn;
    nb = nb + cal_busy;
    nt = nt + dist_tick;
    if (s[1]) chk(obs, q.pop_front());
    if (cyc > 2000) begin
      n_errors = n_errors + 1;
      test_done;
    end
  end
  initial begin
    rst;
    for (i = 0; i < 12; i = i + 1) begin
      lf = nxt(lf);
      cfg({1'b0, lf[0]}, lf[3:1] % 3'h7, lf[4], lf[5], lf[6], lf[8:7], lf[10:9], lf[13:11]);
    end
    idle(4);
    // hiz, up, down, normal positive, normal negative
    for (i = 0; i < 5; i = i + 1) begin
      cfg(2'h0, 3'h0, 1'b0, i == 1, i == 4, 2'h1, (i > 3) ? 2'h3 : i[1:0], 3'h3);
      idle(3);
      @(posedge mclk) {nu, nd, nt} = 0;
      repeat (32) @(negedge mclk);
      @(posedge mclk);
      chk({nu > 0, nd > 0, nu > nd}, (15'h6ea8 >> (3 * i)) & 15'h7);
      chk(nt, (i == 1) ? 16 : 8);
    end
    // run, repeat ignored, clear, rerun
    for (i = 0; i < 4; i = i + 1) begin
      cal_req = i != 2;
      @(posedge mclk) nb = 0;
      cfg(2'h0, 3'h2, 1'b1, 1'b0, 1'b1, 2'h2, 2'h3, 3'h4);
      idle(20);
      chk(nb, (i == 1 || i == 2) ? 0 : 8);
      chk(cal_done, i != 2);
    end
    rst;
    test_done;
  end
endmodule // tb_pcp_top
